// file: design/dse_pkg.sv
// constants for the transfer engine setup and enable protection block
`default_nettype none
package dse_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int unsigned NUM_CH    = 8;
   localparam int unsigned CH_W      = 3;
   localparam int unsigned TIER_N    = 4;
   localparam int unsigned PTR_W     = 32;
   localparam int unsigned CRC_SET_W = 16;
   localparam int unsigned CRC_SUM_W = 32;
   localparam int unsigned BEAT_W    = 2;

   // ------------------------------------------------------------
   // channel_control_second field layout
   // ------------------------------------------------------------
   localparam int unsigned TSRC_LSB = 0;
   localparam int unsigned TSRC_W   = 6;
   localparam int unsigned TACT_LSB = 6;
   localparam int unsigned TACT_W   = 2;
   localparam int unsigned ALVL_LSB = 8;
   localparam int unsigned ALVL_W   = 2;
   localparam int unsigned CMD_LSB  = 10;
   localparam int unsigned CMD_W    = 2;
   localparam int unsigned CCS_W    = 12;

   // fields that stay writable while the channel runs
   localparam logic [CCS_W-1:0] CCS_LIVE_MASK = 12'hf00;
   localparam logic [CCS_W-1:0] CCS_ALL_MASK  = 12'hfff;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [PTR_W-1:0]     PTR_RST     = 32'h0000_0000;
   localparam logic [CRC_SET_W-1:0] CRC_SET_RST = 16'h0000;
   localparam logic [CRC_SUM_W-1:0] CRC_SUM_RST = 32'h0000_0000;
   localparam logic [CCS_W-1:0]     CCS_RST     = 12'h000;
   localparam logic [TIER_N-1:0]    TIER_RST    = 4'h0;
   localparam logic [CH_W-1:0]      CH_IDX_RST  = 3'h0;
   localparam logic [NUM_CH-1:0]    CH_EN_RST   = 8'h00;
   localparam logic [BEAT_W-1:0]    BEAT_RST    = 2'h0;
endpackage
`default_nettype wire

// file: design/dse_chan_mem.sv
// per-channel store of the second channel control register
`timescale 1ns/1ps
`default_nettype none
module dse_chan_mem (
   input  wire logic                      core_clk,
   input  wire logic                      resetn,
   input  wire logic                      clear_all,
   input  wire logic                      wr_en,
   input  wire logic [dse_pkg::CH_W-1:0]  wr_addr,
   input  wire logic [dse_pkg::CCS_W-1:0] wr_data,
   input  wire logic [dse_pkg::CCS_W-1:0] wr_mask,
   input  wire logic [dse_pkg::CH_W-1:0]  rd_addr,
   output logic      [dse_pkg::CCS_W-1:0] rd_data
);
   import dse_pkg::*;

   typedef struct packed {
      logic [NUM_CH-1:0][CCS_W-1:0] mem;
      logic [CCS_W-1:0]             rdata;
   } dse_mem_state_t;

   dse_mem_state_t st;
   dse_mem_state_t next_st;

   // ------------------------------------------------------------
   // masked write, registered read
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      for (int i = 0; i < NUM_CH; i++) begin
         if (clear_all) begin
            next_st.mem[i] = CCS_RST;
         end else if (wr_en && (wr_addr == CH_W'(i))) begin
            next_st.mem[i] = (st.mem[i] & ~wr_mask) | (wr_data & wr_mask);
         end
      end
      // read after write, so a write shows on the next cycle
      next_st.rdata = next_st.mem[rd_addr];
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data = st.rdata;
endmodule
`default_nettype wire

// file: design/dse_setup_protect.sv
// setup registers and enable protection of the transfer engine
// Functional notes
// - base pointers writable only while engine off
// - global reset bit needs engine and crc off
// - second control locked while channel on, except command/level
// - channel reset bit writable only while disabled
// - crc setup and result writable while crc off
// - arbiter serves only enabled priority tiers
// - channel index selects accessed channel registers
// - bus accesses use descriptor access width
// - descriptor usable only when valid bit set
`timescale 1ns/1ps
`default_nettype none
module dse_setup_protect (
   input  wire logic                          core_clk,
   input  wire logic                          resetn,
   input  wire logic                          ctrl_wr,
   input  wire logic                          ctrl_wdata_dma_on,
   input  wire logic                          ctrl_wdata_crc_on,
   input  wire logic [dse_pkg::TIER_N-1:0]    ctrl_wdata_tier_en,
   input  wire logic                          ctrl_wdata_soft_reset,
   input  wire logic                          base_wr,
   input  wire logic [dse_pkg::PTR_W-1:0]     base_wdata,
   input  wire logic                          wb_wr,
   input  wire logic [dse_pkg::PTR_W-1:0]     wb_wdata,
   input  wire logic                          index_wr,
   input  wire logic [dse_pkg::CH_W-1:0]      index_wdata,
   input  wire logic                          cfirst_wr,
   input  wire logic                          cfirst_wdata_enable,
   input  wire logic                          cfirst_wdata_soft_reset,
   input  wire logic                          csecond_wr,
   input  wire logic [dse_pkg::CCS_W-1:0]     csecond_wdata,
   input  wire logic                          crc_setup_wr,
   input  wire logic [dse_pkg::CRC_SET_W-1:0] crc_setup_wdata,
   input  wire logic                          crc_result_wr,
   input  wire logic [dse_pkg::CRC_SUM_W-1:0] crc_result_wdata,
   input  wire logic [dse_pkg::TIER_N-1:0]    tier_request,
   input  wire logic                          desc_load,
   input  wire logic [dse_pkg::CH_W-1:0]      desc_channel,
   input  wire logic                          desc_valid,
   input  wire logic [dse_pkg::BEAT_W-1:0]    desc_beat_size,
   output logic                               dma_global_on,
   output logic                               crc_unit_on,
   output logic      [dse_pkg::TIER_N-1:0]    priority_tier_enable,
   output logic      [dse_pkg::PTR_W-1:0]     descriptor_base_pointer,
   output logic      [dse_pkg::PTR_W-1:0]     writeback_base_pointer,
   output logic      [dse_pkg::CH_W-1:0]      channel_select_index,
   output logic      [dse_pkg::NUM_CH-1:0]    channel_enable,
   output logic      [dse_pkg::CCS_W-1:0]     channel_control_second,
   output logic      [dse_pkg::CRC_SET_W-1:0] crc_setup_register,
   output logic      [dse_pkg::CRC_SUM_W-1:0] crc_result_register,
   output logic      [dse_pkg::TIER_N-1:0]    tier_grant,
   output logic                               desc_usable,
   output logic      [dse_pkg::BEAT_W-1:0]    access_width
);
   import dse_pkg::*;

   typedef struct packed {
      logic                 dma_on;
      logic                 crc_on;
      logic [TIER_N-1:0]    tier_en;
      logic [PTR_W-1:0]     base_ptr;
      logic [PTR_W-1:0]     wb_ptr;
      logic [CH_W-1:0]      ch_idx;
      logic [NUM_CH-1:0]    ch_en;
      logic [CRC_SET_W-1:0] crc_set;
      logic [CRC_SUM_W-1:0] crc_sum;
      logic [TIER_N-1:0]    grant;
      logic                 usable;
      logic [BEAT_W-1:0]    width;
   } dse_state_t;

   dse_state_t        st;
   dse_state_t        next_st;
   logic              glob_reset;
   logic              ch_reset;
   logic              cur_ch_on;
   logic              base_ok;
   logic              wb_ok;
   logic              crc_set_ok;
   logic              crc_sum_ok;
   logic              desc_ch_on;
   logic              mem_wr;
   logic [CCS_W-1:0]  mem_data;
   logic [CCS_W-1:0]  mem_mask;
   logic [CH_W-1:0]   rd_sel;
   logic [TIER_N-1:0] tier_hit;
   logic [TIER_N-1:0] tier_above;
   logic [TIER_N-1:0] tier_pick;

   // ------------------------------------------------------------
   // write qualification
   // ------------------------------------------------------------
   always_comb begin
      cur_ch_on  = st.ch_en[st.ch_idx];
      glob_reset = ctrl_wr && ctrl_wdata_soft_reset
                   && !st.dma_on && !st.crc_on;
      ch_reset   = cfirst_wr && cfirst_wdata_soft_reset && !cur_ch_on;
      base_ok    = base_wr && !st.dma_on;
      wb_ok      = wb_wr && !st.dma_on;
      crc_set_ok = crc_setup_wr && !st.crc_on;
      crc_sum_ok = crc_result_wr && !st.crc_on;
      desc_ch_on = st.ch_en[desc_channel];
   end

   // ------------------------------------------------------------
   // channel store write control
   // ------------------------------------------------------------
   always_comb begin
      mem_wr = ch_reset || csecond_wr;
      if (ch_reset) begin
         mem_data = CCS_RST;
         mem_mask = CCS_ALL_MASK;
      end else if (cur_ch_on) begin
         mem_data = csecond_wdata;
         mem_mask = CCS_LIVE_MASK;
      end else begin
         mem_data = csecond_wdata;
         mem_mask = CCS_ALL_MASK;
      end
   end

   // ------------------------------------------------------------
   // priority tier arbitration
   // ------------------------------------------------------------
   for (genvar g = 0; g < TIER_N; g = g + 1) begin : g_tier
      assign tier_hit[g] = tier_request[g] && st.tier_en[g] && st.dma_on;
      if (g == TIER_N - 1) begin : g_top
         assign tier_above[g] = 1'b0;
      end else begin : g_low
         assign tier_above[g] = |tier_hit[TIER_N-1:g+1];
      end
      assign tier_pick[g] = tier_hit[g] && !tier_above[g];
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (glob_reset) begin
         next_st = '0;
      end else begin
         if (ctrl_wr) begin
            next_st.dma_on  = ctrl_wdata_dma_on;
            next_st.crc_on  = ctrl_wdata_crc_on;
            next_st.tier_en = ctrl_wdata_tier_en;
         end
         if (base_ok) begin
            next_st.base_ptr = base_wdata;
         end
         if (wb_ok) begin
            next_st.wb_ptr = wb_wdata;
         end
         if (index_wr) begin
            next_st.ch_idx = index_wdata;
         end
         if (cfirst_wr) begin
            next_st.ch_en[st.ch_idx] = cfirst_wdata_enable;
         end
         if (crc_set_ok) begin
            next_st.crc_set = crc_setup_wdata;
         end
         if (crc_sum_ok) begin
            next_st.crc_sum = crc_result_wdata;
         end
         // arbiter: highest requesting tier among enabled tiers
         next_st.grant = tier_pick;
         // descriptor fetch outcome
         if (desc_load) begin
            next_st.usable = desc_valid && st.dma_on
                             && desc_ch_on;
            next_st.width  = desc_valid ? desc_beat_size : BEAT_RST;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // per-channel second control store
   // ------------------------------------------------------------
   assign rd_sel = next_st.ch_idx;

   dse_chan_mem u_mem (
      .core_clk (core_clk),
      .resetn   (resetn),
      .clear_all(glob_reset),
      .wr_en    (mem_wr),
      .wr_addr  (st.ch_idx),
      .wr_data  (mem_data),
      .wr_mask  (mem_mask),
      .rd_addr  (rd_sel),
      .rd_data  (channel_control_second)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign dma_global_on           = st.dma_on;
   assign crc_unit_on             = st.crc_on;
   assign priority_tier_enable    = st.tier_en;
   assign descriptor_base_pointer = st.base_ptr;
   assign writeback_base_pointer  = st.wb_ptr;
   assign channel_select_index    = st.ch_idx;
   assign channel_enable          = st.ch_en;
   assign crc_setup_register      = st.crc_set;
   assign crc_result_register     = st.crc_sum;
   assign tier_grant              = st.grant;
   assign desc_usable             = st.usable;
   assign access_width            = st.width;
endmodule
`default_nettype wire

// file: dv/dse_setup_protect_props.sv
// assertion checker for the transfer engine setup and enable protection block
`timescale 1ns/1ps
`default_nettype none
module dse_props import dse_pkg::*; (
   input wire logic                 core_clk,
   input wire logic                 resetn,
   input wire logic                 ctrl_wr,
   input wire logic                 ctrl_wdata_soft_reset,
   input wire logic                 base_wr,
   input wire logic                 wb_wr,
   input wire logic                 index_wr,
   input wire logic                 cfirst_wr,
   input wire logic                 csecond_wr,
   input wire logic                 crc_setup_wr,
   input wire logic                 crc_result_wr,
   input wire logic                 desc_load,
   input wire logic                 desc_valid,
   input wire logic                 dma_global_on,
   input wire logic                 crc_unit_on,
   input wire logic                 desc_usable,
   input wire logic [PTR_W-1:0]     base_wdata,
   input wire logic [PTR_W-1:0]     descriptor_base_pointer,
   input wire logic [PTR_W-1:0]     writeback_base_pointer,
   input wire logic [CRC_SUM_W-1:0] crc_result_wdata,
   input wire logic [CRC_SUM_W-1:0] crc_result_register,
   input wire logic [CRC_SET_W-1:0] crc_setup_register,
   input wire logic [CCS_W-1:0]     csecond_wdata,
   input wire logic [CCS_W-1:0]     channel_control_second,
   input wire logic [CH_W-1:0]      channel_select_index,
   input wire logic [CH_W-1:0]      desc_channel,
   input wire logic [NUM_CH-1:0]    channel_enable,
   input wire logic [TIER_N-1:0]    tier_request,
   input wire logic [TIER_N-1:0]    priority_tier_enable,
   input wire logic [TIER_N-1:0]    tier_grant,
   input wire logic [BEAT_W-1:0]    desc_beat_size,
   input wire logic [BEAT_W-1:0]    access_width
);
   wire logic              ch_on = channel_enable[desc_channel];
   wire logic [TIER_N-1:0] hit   = tier_request & priority_tier_enable;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   sequence s_live_wr;
      csecond_wr && channel_enable[channel_select_index] && !index_wr && !cfirst_wr && !ctrl_wr;
   endsequence
   sequence s_live_kept;
      channel_control_second == {$past(csecond_wdata[11:8]), $past(channel_control_second[7:0])};
   endsequence
   a_pointers_locked: assert property (dma_global_on && (base_wr || wb_wr) |=>
      $stable(descriptor_base_pointer) && $stable(writeback_base_pointer)) else $error("pointer changed while on");
   a_base_taken: assert property (!dma_global_on && base_wr && !ctrl_wr |=>
      descriptor_base_pointer == $past(base_wdata)) else $error("base write lost");
   a_crc_locked: assert property (crc_unit_on && (crc_setup_wr || crc_result_wr) |=>
      $stable(crc_setup_register) && $stable(crc_result_register)) else $error("crc changed while on");
   a_crc_taken: assert property (!crc_unit_on && crc_result_wr && !ctrl_wr |=>
      crc_result_register == $past(crc_result_wdata)) else $error("crc write lost");
   a_reset_refused: assert property ((dma_global_on || crc_unit_on) && ctrl_wr && !base_wr |=>
      $stable(descriptor_base_pointer)) else $error("soft reset acted while on");
   a_reset_clears: assert property (!dma_global_on && !crc_unit_on && ctrl_wr && ctrl_wdata_soft_reset |=>
      descriptor_base_pointer == '0 && crc_result_register == '0 && channel_enable == '0) else $error("no clear");
   a_live_fields: assert property (s_live_wr |=> s_live_kept) else $error("locked fields moved");
   a_grant_when: assert property (##1 (tier_grant != '0) == ($past(dma_global_on) && $past(hit) != '0))
      else $error("grant presence wrong");
   a_grant_top: assert property (tier_grant != '0 |-> $onehot(tier_grant) && ($past(hit) & tier_grant) != '0 &&
      ($past(hit) & ~tier_grant) < tier_grant) else $error("grant not highest tier");
   a_desc_usable: assert property (desc_load && !ctrl_wr && !cfirst_wr |=>
      desc_usable == ($past(desc_valid) && $past(dma_global_on) && $past(ch_on))) else $error("usable wrong");
   a_width_pick: assert property (desc_load && !ctrl_wr |=>
      access_width == ($past(desc_valid) ? $past(desc_beat_size) : '0)) else $error("width wrong");
endmodule
bind dse_setup_protect dse_props u_props (.*);
`default_nettype wire

// file: dv/tb_top.sv
// self-checking testbench for the setup and enable protection block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dse_pkg::*;
   logic                 core_clk = 1'b0;
   logic                 resetn, ctrl_wr, ctrl_wdata_dma_on, ctrl_wdata_crc_on, ctrl_wdata_soft_reset, base_wr, wb_wr;
   logic                 index_wr, cfirst_wr, cfirst_wdata_enable, cfirst_wdata_soft_reset, csecond_wr, crc_setup_wr;
   logic                 crc_result_wr, desc_load, desc_valid, dma_global_on, crc_unit_on, desc_usable;
   logic [TIER_N-1:0]    ctrl_wdata_tier_en, tier_request, priority_tier_enable, tier_grant;
   logic [PTR_W-1:0]     base_wdata, wb_wdata, descriptor_base_pointer, writeback_base_pointer;
   logic [CH_W-1:0]      index_wdata, desc_channel, channel_select_index;
   logic [CCS_W-1:0]     csecond_wdata, channel_control_second;
   logic [CRC_SET_W-1:0] crc_setup_wdata, crc_setup_register;
   logic [CRC_SUM_W-1:0] crc_result_wdata, crc_result_register;
   logic [NUM_CH-1:0]    channel_enable;
   logic [BEAT_W-1:0]    desc_beat_size, access_width;
   int                   miscompares = 0;
   int                   samples_checked = 0;
   dse_setup_protect DUT (.*);
   always #10 core_clk = ~core_clk;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic step();
      @(negedge core_clk);
      {ctrl_wr, base_wr, wb_wr, index_wr, cfirst_wr, csecond_wr, crc_setup_wr, crc_result_wr, desc_load} = '0;
      @(negedge core_clk);
   endtask
   task automatic ctl(input logic d, input logic c, input logic s);
      {ctrl_wr, ctrl_wdata_dma_on, ctrl_wdata_crc_on, ctrl_wdata_soft_reset, ctrl_wdata_tier_en} = {1'b1, d, c, s, 4'h5};
      step();
   endtask
   task automatic cf(input logic en, input logic sr);
      {cfirst_wr, cfirst_wdata_enable, cfirst_wdata_soft_reset} = {1'b1, en, sr};
      step();
   endtask
   task automatic sel(input logic [CH_W-1:0] i);
      {index_wr, index_wdata} = {1'b1, i};
      step();
   endtask
   task automatic sec(input logic [CCS_W-1:0] d);
      {csecond_wr, csecond_wdata} = {1'b1, d};
      step();
   endtask
   task automatic dsc(input logic [CH_W-1:0] ch, input logic v, input logic [1:0] b, input logic u, input logic [1:0] w);
      {desc_load, desc_channel, desc_valid, desc_beat_size} = {1'b1, ch, v, b};
      step();
      chk("usable", u, desc_usable);
      chk("width", w, access_width);
   endtask
   task automatic crcw(input logic [CRC_SET_W-1:0] s, input logic [CRC_SUM_W-1:0] r);
      {crc_setup_wr, crc_setup_wdata, crc_result_wr, crc_result_wdata} = {1'b1, s, 1'b1, r};
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_base();
      chk("flags", 0, {dma_global_on, crc_unit_on, priority_tier_enable, channel_select_index, channel_enable});
      chk("ptrs", 0, descriptor_base_pointer | writeback_base_pointer | crc_result_register);
      {base_wr, base_wdata, wb_wr, wb_wdata} = {1'b1, 32'h2000_0100, 1'b1, 32'h2000_0200};
      ctl(1, 0, 0);
      chk("base", 32'h2000_0100, descriptor_base_pointer);
      chk("wb", 32'h2000_0200, writeback_base_pointer);
      {base_wr, base_wdata, wb_wr, wb_wdata} = {1'b1, 32'hdead_beef, 1'b1, 32'h1234_5678};
      step();
      chk("base", 32'h2000_0100, descriptor_base_pointer);
      chk("wb", 32'h2000_0200, writeback_base_pointer);
      $display("base test done");
   endtask
   task automatic t_crc();
      crcw(16'h1021, 32'hffff_ffff);
      ctl(1, 1, 0);
      chk("crc_set", 16'h1021, crc_setup_register);
      chk("enables", 2'b11, {dma_global_on, crc_unit_on});
      crcw(16'h8005, 32'h0000_0001);
      step();
      chk("crc_set", 16'h1021, crc_setup_register);
      chk("crc_sum", 32'hffff_ffff, crc_result_register);
      $display("crc test done");
   endtask
   task automatic t_gsr();
      ctl(0, 1, 1);
      ctl(0, 1, 1);
      chk("base", 32'h2000_0100, descriptor_base_pointer);
      ctl(0, 0, 0);
      ctl(0, 0, 1);
      chk("base", 0, descriptor_base_pointer);
      chk("crc_sum", 0, crc_result_register);
      $display("soft reset test done");
   endtask
   task automatic t_chan();
      ctl(1, 0, 0);
      sel(3);
      chk("index", 3, channel_select_index);
      sec(12'habc);
      chk("second", 12'habc, channel_control_second);
      cf(1, 0);
      chk("ch_en", 8'h08, channel_enable);
      sec(12'h123);
      chk("second", 12'h1bc, channel_control_second);
      cf(1, 1);
      chk("second", 12'h1bc, channel_control_second);
      for (int b = 0; b < 4; b++) dsc(3, 1, 2'(b), 1, 2'(b));
      dsc(3, 0, 1, 0, 0);
      dsc(4, 1, 3, 0, 3);
      sel(5);
      chk("second", 0, channel_control_second);
      sel(3);
      cf(0, 0);
      cf(0, 1);
      chk("second", 0, channel_control_second);
      $display("channel test done");
   endtask
   task automatic t_arb();
      ctl(1, 0, 0);
      tier_request = 4'hf;
      step();
      chk("grant", 4'h4, tier_grant);
      chk("tiers", 4'h5, priority_tier_enable);
      tier_request = 4'h2;
      step();
      chk("grant", 0, tier_grant);
      ctl(0, 0, 0);
      tier_request = 4'hf;
      step();
      chk("grant", 0, tier_grant);
      $display("arbiter test done");
   endtask
   initial begin
      {resetn, ctrl_wr, ctrl_wdata_dma_on, ctrl_wdata_crc_on, ctrl_wdata_tier_en, ctrl_wdata_soft_reset} = '0;
      {base_wr, base_wdata, wb_wr, wb_wdata, index_wr, index_wdata, cfirst_wr, cfirst_wdata_enable} = '0;
      {cfirst_wdata_soft_reset, csecond_wr, csecond_wdata, crc_setup_wr, crc_setup_wdata, crc_result_wr} = '0;
      {crc_result_wdata, tier_request, desc_load, desc_channel, desc_valid, desc_beat_size} = '0;
      repeat (6) @(negedge core_clk);
      resetn = 1'b1;
      t_base();
      t_crc();
      t_gsr();
      t_chan();
      t_arb();
      stop_test();
   end
   initial begin
      #50000;
      miscompares++;
      stop_test();
   end
endmodule
`default_nettype wire
